// ---- sav_pkg.sv ----
// Shared constants and types for the setup attribute and viewport block
package sav_pkg;
   // ----------------------------------------
   // Viewport and scissor arrays
   // ----------------------------------------
   localparam int VP_ENTRIES = 16;
   localparam int VP_STRIDE_DW = 16;
   localparam int VP_ALIGN_BYTES = 64;
   localparam logic [3:0] DW_SCALE_X = 4'h0;
   localparam logic [3:0] DW_SCALE_Y = 4'h1;
   localparam logic [3:0] DW_SCALE_Z = 4'h2;
   localparam logic [3:0] DW_OFFSET_X = 4'h3;
   localparam logic [3:0] DW_OFFSET_Y = 4'h4;
   localparam logic [3:0] DW_OFFSET_Z = 4'h5;
   localparam logic [3:0] DW_GB_LEFT = 4'h8;
   localparam logic [3:0] DW_GB_TOP = 4'hb;
   localparam logic SC_DW_MIN = 1'b0;
   localparam logic SC_DW_MAX = 1'b1;
   localparam int SC_Y_LSB = 16;
   localparam int SC_X_LSB = 0;
   localparam int SC_W = 16;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // ----------------------------------------
   // Attribute setup
   // ----------------------------------------
   localparam logic [5:0] MAX_OUT_ATTR = 6'h20;
   localparam logic [31:0] FX_ONE = 32'h0001_0000;
   localparam logic [31:0] FX_HALF = 32'h0000_8000;
   localparam logic [31:0] FX_MHALF = 32'hffff_8000;
   localparam logic ORIGIN_TOP_LEFT = 1'b0;
   localparam logic ORIGIN_BOTTOM_LEFT = 1'b1;
   localparam logic [31:0] RST_COUNT = 32'h0000_0000;
   typedef enum logic [1:0] {
      SWZ_DIRECT = 2'b00,
      SWZ_FACING = 2'b01,
      SWZ_W_TO_X = 2'b10,
      SWZ_FACING_W = 2'b11
   } sav_swz_t;
   typedef enum logic [1:0] {
      CSRC_0000 = 2'b00,
      CSRC_0001 = 2'b01,
      CSRC_1111 = 2'b10
   } sav_csrc_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } sav_state_t;
endpackage

// ---- sav_swizzle.sv ----
// Per-vertex attribute swizzle, W-to-X copy and constant override
`timescale 1ns/1ps
`default_nettype none
module sav_swizzle (
   // Source attribute
   input wire logic [127:0] srcVal,
   input wire logic wToX,
   // Constant override
   input wire logic ovrActive,
   input wire logic [3:0] ovrMask,
   input wire logic [1:0] constSel,
   // Result
   output logic [127:0] outVal
);
   import sav_pkg::*;

   // ----------------------------------------
   // Constant source decode
   // ----------------------------------------
   function automatic logic [127:0] constVec(input logic [1:0] sel);
      logic [127:0] v;
      v = '0;
      case (sel)
         CSRC_0001: v = {FX_ONE, 96'h0};
         CSRC_1111: v = {FX_ONE, FX_ONE, FX_ONE, FX_ONE};
         default: v = '0;
      endcase
      return v;
   endfunction

   wire logic [127:0] cVec = constVec(constSel);
   wire logic [127:0] swz = wToX ? {srcVal[127:32], srcVal[127:96]} : srcVal;

   // ----------------------------------------
   // Channel override, X is bit 0
   // ----------------------------------------
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_ch
         assign outVal[c*32 +: 32] = (ovrActive && ovrMask[c]) ? cVec[c*32 +: 32]
                                                               : swz[c*32 +: 32];
      end
   endgenerate
endmodule
`default_nettype wire

// ---- sav_coef.sv ----
// Plane coefficients for constant, linear and wrap-shortest modes
`timescale 1ns/1ps
`default_nettype none
module sav_coef (
   // Vertex values
   input wire logic [127:0] valA0,
   input wire logic [127:0] valA1,
   input wire logic [127:0] valA2,
   // Mode
   input wire logic constInterp,
   input wire logic [3:0] wrapEn,
   // Coefficients
   output logic [127:0] coefA0,
   output logic [127:0] coefA1,
   output logic [127:0] coefA2
);
   import sav_pkg::*;

   // ----------------------------------------
   // Wrap a delta into the shortest range
   // ----------------------------------------
   function automatic logic [31:0] wrapDelta(input logic [31:0] d, input logic en);
      logic [31:0] r;
      r = d;
      if (en && ($signed(d) <= $signed(FX_MHALF))) begin
         r = d + FX_ONE;
      end else if (en && ($signed(d) >= $signed(FX_HALF))) begin
         r = d - FX_ONE;
      end
      return r;
   endfunction

   // ----------------------------------------
   // Per component coefficients
   // ----------------------------------------
   assign coefA0 = valA0;
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_comp
         wire logic [31:0] d1 = valA1[c*32 +: 32] - valA0[c*32 +: 32];
         wire logic [31:0] d2 = valA2[c*32 +: 32] - valA0[c*32 +: 32];
         assign coefA1[c*32 +: 32] = constInterp ? 32'h0 : wrapDelta(d1, wrapEn[c]);
         assign coefA2[c*32 +: 32] = constInterp ? 32'h0 : wrapDelta(d2, wrapEn[c]);
      end
   endgenerate
endmodule
`default_nettype wire

// ---- sav_setup.sv ----
// Attribute setup, viewport state and scissor test of the setup stage
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Sixteen viewport entries, sixteen words apart, aligned
// - Scissor discards Y beyond inclusive maximum
// - Scissor discards X beyond inclusive maximum
// - Minimum above maximum discards all primitives
// - Up to 32 output attributes emitted
// - Input count comes from read length
// - One swizzle enable per sixteen attributes
// - Facing mode picks next input for back
// - W modes copy source W into X
// - Constant source gives 0000, 0001 or 1111
// - Override bit replaces channel with constant
// - Constant mode: a0 provoking, a1 a2 zero
// - Linear mode: a0, A1-A0, A2-A0
// - Wrap shortest adjusts deltas at or past half
// - Points replicate center attributes to corners
// - Sprite mask picks generated texture coordinates
// - Sprite corners follow selected origin
// - Statistics count each received object
module sav_setup (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Viewport and scissor state load
   input wire logic vpWr,
   input wire logic [7:0] vpAddr,
   input wire logic scWr,
   input wire logic [4:0] scAddr,
   input wire logic [31:0] stData,
   // Setup stage command state
   input wire logic [5:0] numOutAttr,
   input wire logic [4:0] readLength,
   input wire logic swzEnable,
   input wire logic swzUpper,
   input wire logic [15:0][1:0] swzSelect,
   input wire logic [15:0][4:0] inputIndex,
   input wire logic [15:0][1:0] constSource,
   input wire logic [15:0][3:0] compOverride,
   input wire logic [31:0] constInterp,
   input wire logic [15:0][3:0] wrapEnable,
   input wire logic [31:0] spriteEnable,
   input wire logic spriteOrigin,
   input wire logic statsEnable,
   input wire logic scissorEnable,
   // Input attribute array load
   input wire logic inWr,
   input wire logic [1:0] inVtx,
   input wire logic [4:0] inIdx,
   input wire logic [127:0] inData,
   // Object from clip stage
   input wire logic objValid,
   output logic objReady,
   input wire logic [3:0] objVpIndex,
   input wire logic objFront,
   input wire logic objPoint,
   input wire logic [1:0] objCorner,
   // Object state to windower
   output logic objDiscard_r,
   output logic [3:0][31:0] guardband_r,
   output logic [5:0][31:0] vpMatrix_r,
   // Attribute coefficients to windower
   output logic attrValid_r,
   output logic [4:0] attrNum_r,
   output logic attrPoint_r,
   output logic [127:0] coefA0_r,
   output logic [127:0] coefA1_r,
   output logic [127:0] coefA2_r,
   output logic objDone_r,
   // Pixel scissor test
   input wire logic pixValid,
   input wire logic [3:0] pixVpIndex,
   input wire logic [15:0] pixX,
   input wire logic [15:0] pixY,
   output logic pixOutValid_r,
   output logic pixKill_r,
   // Statistics
   output logic [31:0] clipperOutputCount_r
);
   import sav_pkg::*;

   // ----------------------------------------
   // State storage
   // ----------------------------------------
   logic [31:0] vpMat [0:15][0:5];
   logic [31:0] vpGb [0:15][0:3];
   logic [31:0] scMin [0:15];
   logic [31:0] scMax [0:15];
   logic [127:0] inArr [0:2][0:31];
   sav_state_t state_r;
   sav_state_t state_nxt;
   logic [4:0] attrIdx_r;
   logic [3:0] curVp_r;
   logic curFront_r;
   logic curPoint_r;
   logic [1:0] curCorner_r;

   // Viewport word decode: entry in high nibble, word in low nibble
   wire logic [3:0] vpEntry = vpAddr[7:4];
   wire logic [3:0] vpWord = vpAddr[3:0];
   wire logic vpMatHit = vpWr && (vpWord <= DW_OFFSET_Z);
   wire logic vpGbHit = vpWr && (vpWord >= DW_GB_LEFT) && (vpWord <= DW_GB_TOP);
   wire logic [3:0] scEntry = scAddr[4:1];

   // Viewport and scissor arrays, reserved words dropped
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int e = 0; e < VP_ENTRIES; e++) begin
            for (int w = 0; w < 6; w++) begin
               vpMat[e][w] <= RST_WORD;
            end
            for (int w = 0; w < 4; w++) begin
               vpGb[e][w] <= RST_WORD;
            end
            scMin[e] <= RST_WORD;
            scMax[e] <= RST_WORD;
         end
      end else begin
         if (vpMatHit) begin
            vpMat[vpEntry][vpWord[2:0]] <= stData;
         end
         if (vpGbHit) begin
            vpGb[vpEntry][vpWord[1:0]] <= stData;
         end
         if (scWr && (scAddr[0] == SC_DW_MIN)) begin
            scMin[scEntry] <= stData;
         end
         if (scWr && (scAddr[0] == SC_DW_MAX)) begin
            scMax[scEntry] <= stData;
         end
      end
   end

   // Input attributes of the three vertices
   always_ff @(posedge sys_clk) begin
      if (inWr && (inVtx != 2'h3)) begin
         inArr[inVtx][inIdx] <= inData;
      end
   end

   // ----------------------------------------
   // Scissor test
   // ----------------------------------------
   function automatic logic degenerate(input logic [31:0] mn, input logic [31:0] mx);
      return (mn[SC_X_LSB +: SC_W] > mx[SC_X_LSB +: SC_W]) ||
             (mn[SC_Y_LSB +: SC_W] > mx[SC_Y_LSB +: SC_W]);
   endfunction

   wire logic [31:0] pMin = scMin[pixVpIndex];
   wire logic [31:0] pMax = scMax[pixVpIndex];
   wire logic yOut = (pixY > pMax[SC_Y_LSB +: SC_W]) || (pixY < pMin[SC_Y_LSB +: SC_W]);
   wire logic xOut = (pixX > pMax[SC_X_LSB +: SC_W]) || (pixX < pMin[SC_X_LSB +: SC_W]);
   wire logic pixDrop = scissorEnable && (yOut || xOut || degenerate(pMin, pMax));

   // Pixel verdict one cycle after the request
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pixOutValid_r <= 1'b0;
         pixKill_r <= 1'b0;
      end else begin
         pixOutValid_r <= pixValid;
         pixKill_r <= pixValid && pixDrop;
      end
   end

   // ----------------------------------------
   // Object acceptance and viewport fetch
   // ----------------------------------------
   assign objReady = (state_r == ST_IDLE);
   wire logic objTake = objValid && objReady;
   wire logic [5:0] outCount = (numOutAttr > MAX_OUT_ATTR) ? MAX_OUT_ATTR : numOutAttr;
   wire logic objDrop = degenerate(scMin[objVpIndex], scMax[objVpIndex]);
   wire logic [127:0] gbSel = {vpGb[objVpIndex][3], vpGb[objVpIndex][2],
                               vpGb[objVpIndex][1], vpGb[objVpIndex][0]};

   // Latch the viewport entry of the accepted object
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         objDiscard_r <= 1'b0;
         guardband_r <= '0;
         vpMatrix_r <= '0;
      end else if (objTake) begin
         objDiscard_r <= objDrop;
         guardband_r <= gbSel;
         for (int w = 0; w < 6; w++) begin
            vpMatrix_r[w] <= vpMat[objVpIndex][w];
         end
      end
   end

   // ----------------------------------------
   // Attribute sequencer
   // ----------------------------------------
   wire logic lastAttr = ({1'b0, attrIdx_r} == (outCount - 6'h01));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (objTake && (outCount != 6'h00)) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (lastAttr) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Sequencer state and per-object flags
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         attrIdx_r <= 5'h00;
         curVp_r <= 4'h0;
         curFront_r <= 1'b0;
         curPoint_r <= 1'b0;
         curCorner_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         if (objTake) begin
            attrIdx_r <= 5'h00;
            curVp_r <= objVpIndex;
            curFront_r <= objFront;
            curPoint_r <= objPoint;
            curCorner_r <= objCorner;
         end else if (state_r == ST_RUN) begin
            attrIdx_r <= attrIdx_r + 5'h01;
         end
      end
   end

   // ----------------------------------------
   // Source selection and swizzle
   // ----------------------------------------
   wire logic [3:0] gIdx = attrIdx_r[3:0];
   wire logic inGroup = swzEnable && (attrIdx_r[4] == swzUpper);
   wire logic [1:0] selMode = swzSelect[gIdx];
   wire logic facingMode = (selMode == SWZ_FACING) || (selMode == SWZ_FACING_W);
   wire logic wMode = (selMode == SWZ_W_TO_X) || (selMode == SWZ_FACING_W);
   wire logic [5:0] backStep = (facingMode && !curFront_r) ? 6'h01 : 6'h00;
   wire logic [5:0] srcEff = inGroup ? ({1'b0, inputIndex[gIdx]} + backStep)
                                     : {1'b0, attrIdx_r};
   wire logic [5:0] inCount = {readLength, 1'b0};
   wire logic srcInRange = (srcEff < inCount);
   wire logic [127:0] swzVal [0:2];

   genvar v;
   generate
      for (v = 0; v < 3; v++) begin : g_vtx
         // Points take every corner from the center vertex
         wire logic [1:0] vSel = curPoint_r ? 2'h0 : 2'(v);
         wire logic [127:0] raw = srcInRange ? inArr[vSel][srcEff[4:0]] : 128'h0;
         sav_swizzle u_swz (
            .srcVal(raw),
            .wToX(inGroup && wMode),
            .ovrActive(inGroup),
            .ovrMask(compOverride[gIdx]),
            .constSel(constSource[gIdx]),
            .outVal(swzVal[v])
         );
      end
   endgenerate

   // ----------------------------------------
   // Coefficients and point sprites
   // ----------------------------------------
   wire logic [127:0] cA0;
   wire logic [127:0] cA1;
   wire logic [127:0] cA2;
   wire logic [3:0] wrapSel = attrIdx_r[4] ? 4'h0 : wrapEnable[gIdx];

   sav_coef u_coef (
      .valA0(swzVal[0]),
      .valA1(swzVal[1]),
      .valA2(swzVal[2]),
      .constInterp(constInterp[attrIdx_r]),
      .wrapEn(wrapSel),
      .coefA0(cA0),
      .coefA1(cA1),
      .coefA2(cA2)
   );

   // Corner bit 0 is right, bit 1 is bottom
   wire logic sprS = curCorner_r[0];
   wire logic sprT = curCorner_r[1] ^ (spriteOrigin == ORIGIN_BOTTOM_LEFT);
   wire logic [127:0] sprVal = {FX_ONE, 32'h0, sprT ? FX_ONE : 32'h0, sprS ? FX_ONE : 32'h0};
   wire logic useSprite = curPoint_r && spriteEnable[attrIdx_r];
   wire logic [127:0] pointA0 = useSprite ? sprVal : swzVal[0];

   // Registered coefficient stream
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         attrValid_r <= 1'b0;
         attrNum_r <= 5'h00;
         attrPoint_r <= 1'b0;
         coefA0_r <= '0;
         coefA1_r <= '0;
         coefA2_r <= '0;
         objDone_r <= 1'b0;
      end else begin
         attrValid_r <= (state_r == ST_RUN);
         objDone_r <= (state_r == ST_RUN) && lastAttr;
         if (state_r == ST_RUN) begin
            attrNum_r <= attrIdx_r;
            attrPoint_r <= curPoint_r;
            coefA0_r <= curPoint_r ? pointA0 : cA0;
            coefA1_r <= curPoint_r ? 128'h0 : cA1;
            coefA2_r <= curPoint_r ? 128'h0 : cA2;
         end
      end
   end

   // ----------------------------------------
   // Statistics
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         clipperOutputCount_r <= RST_COUNT;
      end else if (objTake && statsEnable) begin
         clipperOutputCount_r <= clipperOutputCount_r + 32'h1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   chk_scissor_y: assert property (pixValid && scissorEnable && (pixY > pMax[31:16]) |=> pixKill_r)
      else $error("pixel below scissor bottom kept");
   chk_scissor_x: assert property (pixValid && scissorEnable && (pixX > pMax[15:0]) |=> pixKill_r)
      else $error("pixel right of scissor kept");
   chk_degenerate_drop: assert property (objTake && objDrop |=> objDiscard_r)
      else $error("inverted scissor did not discard");
   chk_attr_count: assert property (attrValid_r |-> ({1'b0, attrNum_r} < outCount))
      else $error("attribute beyond programmed count");
   chk_const_zero: assert property (attrValid_r && !attrPoint_r && $past(constInterp[attrIdx_r])
                                    |-> (coefA1_r == 128'h0) && (coefA2_r == 128'h0))
      else $error("constant attribute has nonzero slope");
   chk_stats_count: assert property (objTake && statsEnable
                                     |=> clipperOutputCount_r == $past(clipperOutputCount_r) + 32'h1)
      else $error("object not counted");
   chk_sprite_origin: assert property (attrValid_r && $past(useSprite) && ($past(curCorner_r) == 2'h0)
                                       && (spriteOrigin == ORIGIN_TOP_LEFT) |-> coefA0_r == {FX_ONE, 96'h0})
      else $error("top-left sprite corner wrong");
   chk_vp_fetch: assert property (objTake |=> guardband_r == $past(gbSel))
      else $error("guardband not from object viewport");
   chk_obj_walk: assert property (objTake && (outCount == 6'h02) |=> ##1 attrValid_r [*2] ##1 !attrValid_r)
      else $error("attribute burst length wrong");

   cov_point_obj: cover property (attrValid_r && attrPoint_r);
   cov_drop_obj: cover property (objTake && objDrop);
   cov_pix_kill: cover property (pixKill_r);
   cov_wrap_attr: cover property ((state_r == ST_RUN) && (wrapSel != 4'h0));
endmodule
`default_nettype wire

// ---- sav_clip_model.sv ----
// Clip stage model that offers objects to the setup block
`timescale 1ns/1ps
`default_nettype none
module sav_clip_model (
   // Clock
   input wire logic sys_clk,
   // Object handshake
   input wire logic objReady,
   output logic objValid,
   output logic [3:0] objVpIndex,
   output logic objFront,
   output logic objPoint,
   output logic [1:0] objCorner
);
   logic taken;
   // Idle with no object offered
   initial begin
      objValid = 1'h0;
      {objVpIndex, objFront, objPoint, objCorner} = 8'h55;
   end
   // Offer one object, held until taken or for at most 50 cycles
   task automatic send(input logic [3:0] vp, input logic fr, pt, input logic [1:0] cr);
      taken = 1'h0;
      @(negedge sys_clk);
      objValid = 1'h1;
      {objVpIndex, objFront, objPoint, objCorner} = {vp, fr, pt, cr};
      for (int i = 0; i < 50 && !taken; i++) begin
         @(posedge sys_clk);
         taken = objReady;
      end
      @(negedge sys_clk);
      objValid = 1'h0;
      // Released fields stop showing the object
      {objVpIndex, objFront, objPoint, objCorner} = ~{vp, fr, pt, cr};
   endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the setup attribute and viewport block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sav_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic sys_clk, rst_b, vpWr, scWr, inWr, swzEnable, swzUpper, spriteOrigin, statsEnable, scissorEnable;
   logic pixValid, objValid, objReady, objFront, objPoint, objDiscard_r, attrValid_r, attrPoint_r;
   logic objDone_r, pixOutValid_r, pixKill_r;
   logic [1:0] inVtx, objCorner;
   logic [3:0] objVpIndex, pixVpIndex;
   logic [4:0] scAddr, readLength, inIdx, attrNum_r;
   logic [5:0] numOutAttr;
   logic [7:0] vpAddr;
   logic [15:0] pixX, pixY;
   logic [31:0] stData, constInterp, spriteEnable, clipperOutputCount_r;
   logic [127:0] inData, coefA0_r, coefA1_r, coefA2_r;
   logic [15:0][1:0] swzSelect, constSource;
   logic [15:0][4:0] inputIndex;
   logic [15:0][3:0] compOverride, wrapEnable;
   logic [3:0][31:0] guardband_r;
   logic [5:0][31:0] vpMatrix_r;
   logic [127:0] a0q [32], a1q [32], a2q [32];
   int nFail = 0, samplesChecked = 0, nAttr = 0, nDone = 0, cyc = 0, ptExp = 0;
   sav_setup u_sav_setup (.*);
   sav_clip_model u_sav_clip_model (.*);
   // Clock of 40 ns
   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Collect coefficients and cut a hang short
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (attrValid_r === 1'h1) begin
         chk("attrNum_r", attrNum_r, nAttr);
         chk("attrPoint_r", attrPoint_r, ptExp);
         a0q[attrNum_r] <= coefA0_r;
         a1q[attrNum_r] <= coefA1_r;
         a2q[attrNum_r] <= coefA2_r;
         nAttr <= nAttr + 1;
      end
      if (objDone_r === 1'h1) nDone <= nDone + 1;
      if (cyc == 20000) begin
         nFail++;
         end_of_test;
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [191:0] seen, exp);
      samplesChecked++;
      if (seen !== exp) begin
         nFail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One state word; k picks viewport, scissor or input
   task automatic wr(input int k, input logic [7:0] a, input logic [127:0] d);
      {vpAddr, scAddr, inVtx, inIdx, stData, inData} = {a, a[4:0], a[6:5], a[4:0], d[31:0], d};
      {vpWr, scWr, inWr} = 3'h4 >> k;
      @(negedge sys_clk);
      {vpWr, scWr, inWr} = 3'h0;
      @(negedge sys_clk);
   endtask
   // One pixel, verdict looked at next cycle
   task automatic pix(input logic [3:0] vp, input logic [15:0] x, y, input logic kill);
      {pixValid, pixVpIndex, pixX, pixY} = {1'h1, vp, x, y};
      @(negedge sys_clk);
      {pixValid, pixVpIndex, pixX, pixY} = {1'h0, ~vp, ~x, ~y};
      chk("pixOutValid_r", pixOutValid_r, 1'h1);
      chk("pixKill_r", pixKill_r, kill);
      @(negedge sys_clk);
   endtask
   // One object through the partner until its attributes are out
   task automatic run_obj(input logic [3:0] vp, input logic fr, pt, input logic [1:0] cr);
      {nAttr, nDone, ptExp} = {64'h0, 31'h0, pt};
      u_sav_clip_model.send(vp, fr, pt, cr);
      for (int i = 0; i < 60 && objReady !== 1'h1; i++) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
   endtask
   // Input values for the coefficient test
   function automatic logic [127:0] dat(input int v, i);
      case (i)
         0: dat = v == 0 ? '0 : v == 1 ? 128'hffffc000_ffff8000_00004000_00008000 : 128'h7fff;
         3, 4: dat = {4{32'h0007_0000}};
         default: dat = {4{v == 0 ? 32'h0003_0000 : v == 1 ? 32'h0001_0000 : 32'h0005_0000}};
      endcase
   endfunction
   function automatic logic [127:0] sw(input int i);
      sw = {32'h0000_0d00 + i, 32'h0000_0c00 + i, 32'h0000_0b00 + i, 32'h0000_0a00 + i};
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("objReady", objReady, 1'h1);
      run_obj(4'h5, 1'h1, 1'h0, 2'h0);
      chk("guardband_r", guardband_r, {4{RST_WORD}});
      chk("vpMatrix_r", vpMatrix_r, {6{RST_WORD}});
      chk("clipperOutputCount_r", clipperOutputCount_r, RST_COUNT);
      chk("nAttr", nAttr + nDone, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_view;
      statsEnable = 1'h1; // Statistics on, objects count
      for (int w = 0; w < 16; w++) begin
         wr(0, {4'hf, w[3:0]}, 128'h000f_0000 + w);
         wr(0, {4'h2, w[3:0]}, 128'h0002_0000 + w);
      end
      run_obj(4'hf, 1'h1, 1'h0, 2'h0);
      for (int i = 0; i < 6; i++) chk("vpMatrix_r", vpMatrix_r[i], 32'h000f_0000 + i);
      for (int i = 0; i < 4; i++) chk("guardband_r", guardband_r[i], 32'h000f_0008 + i);
      run_obj(4'h2, 1'h1, 1'h0, 2'h0);
      chk("guardband_r", guardband_r[3], 32'h0002_000b);
      chk("clipperOutputCount_r", clipperOutputCount_r, 32'h0000_0002);
      statsEnable = 1'h0; // Statistics off, objects not counted
      run_obj(4'h2, 1'h1, 1'h0, 2'h0);
      chk("clipperOutputCount_r", clipperOutputCount_r, 32'h0000_0002);
      $display("test viewport done");
   endtask
   task automatic t_sciss;
      scissorEnable = 1'h1;
      wr(1, 8'h06, 128'h000a_0014);
      wr(1, 8'h07, 128'h0064_3fff);
      wr(1, 8'h08, 128'h0000_0009);
      wr(1, 8'h09, 128'h0064_0008);
      pix(4'h3, 16'h0014, 16'h000a, 1'h0);
      pix(4'h3, 16'h3fff, 16'h0064, 1'h0);
      pix(4'h3, 16'h0013, 16'h0032, 1'h1);
      pix(4'h3, 16'h4000, 16'h0032, 1'h1);
      pix(4'h3, 16'h0032, 16'h0009, 1'h1);
      pix(4'h3, 16'h0032, 16'h0065, 1'h1);
      pix(4'h4, 16'h0009, 16'h0005, 1'h1);
      run_obj(4'h4, 1'h1, 1'h0, 2'h0);
      chk("objDiscard_r", objDiscard_r, 1'h1);
      run_obj(4'h3, 1'h1, 1'h0, 2'h0);
      chk("objDiscard_r", objDiscard_r, 1'h0);
      scissorEnable = 1'h0;
      pix(4'h3, 16'h0032, 16'h0065, 1'h0);
      $display("test scissor done");
   endtask
   task automatic t_coef;
      readLength = 5'h02;
      numOutAttr = 6'h05;
      constInterp = 32'h0000_0004;
      wrapEnable[0] = 4'hf; // Wrap only off constant attributes
      for (int i = 0; i < 5; i++) for (int v = 0; v < 3; v++) wr(2, {1'h0, v[1:0], i[4:0]}, dat(v, i));
      run_obj(4'h0, 1'h1, 1'h0, 2'h0);
      chk("nAttr", nAttr + nDone, 8'h06);
      chk("coefA1_r", a1q[0], 128'hffffc000_00008000_00004000_ffff8000);
      chk("coefA2_r", a2q[0], 128'h7fff);
      chk("coefA0_r", a0q[1], {4{32'h0003_0000}});
      chk("coefA1_r", a1q[1], {4{32'hfffe_0000}});
      chk("coefA2_r", a2q[1], {4{32'h0002_0000}});
      chk("coefA0_r", a0q[2], {4{32'h0003_0000}});
      chk("coefA1_r", a1q[2] | a2q[2], 128'h0);
      chk("coefA0_r", a0q[3], {4{32'h0007_0000}});
      chk("coefA0_r", a0q[4], 128'h0);
      numOutAttr = 6'h21;
      run_obj(4'h0, 1'h1, 1'h0, 2'h0);
      chk("nAttr", nAttr, 8'h20);
      $display("test coef done");
   endtask
   task automatic t_swz;
      {readLength, numOutAttr, constInterp, wrapEnable, swzEnable} = {5'h04, 6'h04, 96'h0, 1'h1};
      swzSelect = {24'h0, SWZ_DIRECT, SWZ_FACING_W, SWZ_W_TO_X, SWZ_FACING};
      inputIndex = {16{5'h05}}; // Facing never uses index 31
      constSource = {24'h0, CSRC_0001, 2'h0, CSRC_1111, CSRC_0000};
      compOverride = {48'h0, 4'h9, 4'h0, 4'h2, 4'h4};
      for (int i = 0; i < 7; i++) for (int v = 0; v < 3; v++) wr(2, {1'h0, v[1:0], i[4:0]}, sw(i));
      run_obj(4'h0, 1'h0, 1'h0, 2'h0);
      chk("coefA0_r", a0q[0], 128'h00000d06_00000000_00000b06_00000a06);
      chk("coefA0_r", a0q[1], 128'h00000d05_00000c05_00010000_00000d05);
      chk("coefA0_r", a0q[2], 128'h00000d06_00000c06_00000b06_00000d06);
      chk("coefA0_r", a0q[3], 128'h00010000_00000c05_00000b05_00000000);
      run_obj(4'h0, 1'h1, 1'h0, 2'h0);
      chk("coefA0_r", a0q[0], 128'h00000d05_00000000_00000b05_00000a05);
      chk("coefA0_r", a0q[2], 128'h00000d05_00000c05_00000b05_00000d05);
      swzUpper = 1'h1;
      run_obj(4'h0, 1'h0, 1'h0, 2'h0);
      chk("coefA0_r", a0q[0], sw(0));
      chk("coefA0_r", a0q[3], sw(3));
      $display("test swizzle done");
   endtask
   task automatic t_sprite;
      {swzEnable, numOutAttr, spriteEnable} = {1'h0, 6'h02, 32'h0000_0001};
      for (int o = 0; o < 2; o++) for (int c = 0; c < 4; c++) begin
         spriteOrigin = o[0];
         run_obj(4'h0, 1'h1, 1'h1, c[1:0]);
         chk("coefA0_r", a0q[0], {FX_ONE, 32'h0, c[1] ^ o[0] ? FX_ONE : 32'h0, c[0] ? FX_ONE : 32'h0});
         chk("coefA0_r", a0q[1], sw(1));
         chk("coefA1_r", a1q[1] | a2q[0], 128'h0);
      end
      $display("test sprite done");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b = 1'h0;
      {vpWr, scWr, inWr, swzEnable, swzUpper, spriteOrigin, statsEnable, scissorEnable, pixValid} = '0;
      {vpAddr, scAddr, readLength, inIdx, stData, constInterp, spriteEnable, numOutAttr} = '0;
      {swzSelect, constSource, inputIndex, compOverride, wrapEnable, inVtx, inData, pixVpIndex, pixX, pixY} = '0;
      repeat (5) @(negedge sys_clk);
      rst_b = 1'h1;
      t_reset;
      t_view;
      t_sciss;
      t_coef;
      t_swz;
      t_sprite;
      end_of_test;
   end
endmodule
`default_nettype wire
